/* File: shared/spims_regs.svh */
// constants for the mode 3 serial slave port
`ifndef SPIMS_REGS_SVH
`define SPIMS_REGS_SVH
`define SPIMS_WORD_BITS 8
`define SPIMS_CNT_W 3
`define SPIMS_LAST_BIT 3'h7
`define SPIMS_SYS_CLK_KHZ 125000
`define SPIMS_SIO_SLOW_HZ 500
`define SPIMS_SIO_SLOW_CYC ((`SPIMS_SYS_CLK_KHZ * 1000) / `SPIMS_SIO_SLOW_HZ)
`define SPIMS_FMT_BARE 1'h0
`define SPIMS_FMT_FULL 1'h1
`endif

/* File: shared/spims_pkg.sv */
// types for the mode 3 serial slave port
package spims_pkg;
  typedef enum logic [1:0] {
    SPIMS_ST_OFF = 2'h0,
    SPIMS_ST_IDLE = 2'h1,
    SPIMS_ST_SHIFT = 2'h3
  } spims_state_t;
  typedef logic [7:0] spims_byte_t;
endpackage

/* File: core/spims_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module spims_sync2
#(
  parameter logic RESET_VAL = 1'h0
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb
  begin
    meta_nxt = d_in;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= RESET_VAL;
      q_out <= RESET_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_out <= q_nxt;
    end
  end
endmodule

/* File: core/spims_sio_pacer.sv */
// update pacer for the shift-register i/o port
`timescale 1ns/10ps
`include "spims_regs.svh"
module spims_sio_pacer
#(
  parameter int SLOW_CYC = `SPIMS_SIO_SLOW_CYC
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic req_in,
  output logic grant_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic grant_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    grant_nxt = 1'h0;
    if (!slow_in)
    begin
      cnt_nxt = 32'h0;
      grant_nxt = req_in;
    end
    else if (cnt_r != 32'h0)
    begin
      cnt_nxt = cnt_r - 32'h1;
    end
    else if (req_in)
    begin
      grant_nxt = 1'h1;
      cnt_nxt = 32'(SLOW_CYC - 1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_r <= 32'h0;
      grant_out <= 1'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      grant_out <= grant_nxt;
    end
  end
endmodule

/* File: core/spims_port.sv */
// mode 3 serial slave port with byte handoff to the system domain
`timescale 1ns/10ps
`include "spims_regs.svh"
module spims_port
#(
  parameter int WORD_BITS = `SPIMS_WORD_BITS,
  parameter int SIO_SLOW_CYC = `SPIMS_SIO_SLOW_CYC
)
(
  // system
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // link side, master clock domain
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic slave_data_input_in,
  output logic slave_data_output_out,
  output logic slave_data_output_oe_out,
  // configuration
  input wire logic spi_enable_in,
  input wire logic frame_full_in,
  // parallel side
  input wire logic [7:0] tx_byte_in,
  output logic tx_take_out,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic active_out,
  output logic async_serial_sel_out,
  output logic frame_full_out,
  // shift-register i/o pacing
  input wire logic sio_req_in,
  output logic sio_grant_out
);
  // ==========================================================
  // synchronisers
  logic clk_s;
  logic cs_n_s;
  logic mosi_s;

  // clock and select idle high, so their flops reset high
  spims_sync2 #(
    .RESET_VAL(1'h1)
  ) u_sync_clk
  (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .d_in(spi_clk_in),
    .q_out(clk_s)
  );
  spims_sync2 #(
    .RESET_VAL(1'h1)
  ) u_sync_cs
  (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .d_in(cs_n_in),
    .q_out(cs_n_s)
  );
  spims_sync2 u_sync_mosi
  (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .d_in(slave_data_input_in),
    .q_out(mosi_s)
  );

  // ==========================================================
  // edge detection and shifter
  spims_pkg::spims_state_t state_r;
  spims_pkg::spims_state_t state_nxt;
  logic clk_d_r;
  logic clk_d_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic [7:0] rx_byte_nxt;
  logic rx_valid_nxt;
  logic tx_take_nxt;
  logic miso_nxt;
  logic oe_nxt;
  logic rise;
  logic fall;
  logic sel;

  always_comb
  begin
    clk_d_nxt = clk_s;
    // mode 3: idle high, fall leads, rise samples
    rise = clk_s & ~clk_d_r;
    fall = ~clk_s & clk_d_r;
    sel = ~cs_n_s & spi_enable_in;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    rx_byte_nxt = rx_byte_out;
    rx_valid_nxt = 1'h0;
    tx_take_nxt = 1'h0;
    miso_nxt = slave_data_output_out;
    oe_nxt = 1'h0;
    case (state_r)
      spims_pkg::SPIMS_ST_OFF:
      begin
        cnt_nxt = 3'h0;
        if (spi_enable_in && cs_n_s)
        begin
          state_nxt = spims_pkg::SPIMS_ST_IDLE;
        end
      end
      spims_pkg::SPIMS_ST_IDLE:
      begin
        cnt_nxt = 3'h0;
        if (!spi_enable_in)
        begin
          state_nxt = spims_pkg::SPIMS_ST_OFF;
        end
        else if (sel)
        begin
          // drive now; the first bit goes out on the first leading edge
          oe_nxt = 1'h1;
          state_nxt = spims_pkg::SPIMS_ST_SHIFT;
        end
      end
      spims_pkg::SPIMS_ST_SHIFT:
      begin
        if (!sel)
        begin
          // deselect: byte boundary restored, line released
          cnt_nxt = 3'h0;
          oe_nxt = 1'h0;
          state_nxt = spi_enable_in ? spims_pkg::SPIMS_ST_IDLE
                                    : spims_pkg::SPIMS_ST_OFF;
        end
        else
        begin
          oe_nxt = 1'h1;
          if (rise)
          begin
            rx_sh_nxt = {rx_sh_r[6:0], mosi_s};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'(WORD_BITS - 1))
            begin
              rx_byte_nxt = {rx_sh_r[6:0], mosi_s};
              rx_valid_nxt = 1'h1;
            end
          end
          else if (fall && cnt_r != 3'h0)
          begin
            miso_nxt = tx_sh_r[7];
            tx_sh_nxt = {tx_sh_r[6:0], 1'h0};
          end
          else if (fall)
          begin
            // new byte, msb first, on the first leading edge of a byte
            miso_nxt = tx_byte_in[7];
            tx_sh_nxt = {tx_byte_in[6:0], 1'h0};
            tx_take_nxt = 1'h1;
          end
        end
      end
      default:
      begin
        state_nxt = spims_pkg::SPIMS_ST_OFF;
      end
    endcase
  end

  // clock and select are inputs only
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= spims_pkg::SPIMS_ST_OFF;
      clk_d_r <= 1'h1;
      cnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      rx_byte_out <= 8'h00;
      rx_valid_out <= 1'h0;
      tx_take_out <= 1'h0;
      slave_data_output_out <= 1'h1;
      slave_data_output_oe_out <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      clk_d_r <= clk_d_nxt;
      cnt_r <= cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_byte_out <= rx_byte_nxt;
      rx_valid_out <= rx_valid_nxt;
      tx_take_out <= tx_take_nxt;
      slave_data_output_out <= miso_nxt;
      slave_data_output_oe_out <= oe_nxt;
    end
  end

  // ==========================================================
  // configuration status
  logic active_nxt;
  logic async_nxt;
  logic full_nxt;

  always_comb
  begin
    active_nxt = (state_nxt == spims_pkg::SPIMS_ST_SHIFT);
    async_nxt = ~spi_enable_in;
    full_nxt = spi_enable_in ? frame_full_in
                             : `SPIMS_FMT_BARE;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      active_out <= 1'h0;
      async_serial_sel_out <= 1'h1;
      frame_full_out <= `SPIMS_FMT_BARE;
    end
    else
    begin
      active_out <= active_nxt;
      async_serial_sel_out <= async_nxt;
      frame_full_out <= full_nxt;
    end
  end

  // ==========================================================
  // shift-register i/o pacing
  spims_sio_pacer #(
    .SLOW_CYC(SIO_SLOW_CYC)
  ) u_pacer
  (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .slow_in(spi_enable_in),
    .req_in(sio_req_in),
    .grant_out(sio_grant_out)
  );
endmodule

/* File: tb/spims_props.sv */
// assertion checker for the mode 3 serial slave port
`timescale 1ns/10ps
module spims_props
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic spi_enable_in,
  input wire logic frame_full_in,
  input wire logic sio_req_in,
  input wire logic slave_data_output_out,
  input wire logic slave_data_output_oe_out,
  input wire logic [7:0] rx_byte_out,
  input wire logic rx_valid_out,
  input wire logic tx_take_out,
  input wire logic async_serial_sel_out,
  input wire logic frame_full_out,
  input wire logic sio_grant_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  release_oe_a: assert property (cs_n_in [*6] |->
    !slave_data_output_oe_out) else $error("oe high while deselected");
  off_quiet_a: assert property (!spi_enable_in [*8] |->
    !slave_data_output_oe_out) else $error("oe high while disabled");
  sel_track_a: assert property (1 |=>
    async_serial_sel_out == !$past(spi_enable_in)) else $error("async sel");
  frame_pass_a: assert property (1 |=> frame_full_out ==
    ($past(frame_full_in) && $past(spi_enable_in))) else $error("frame");
  rx_hold_a: assert property ($changed(rx_byte_out) |->
    rx_valid_out) else $error("rx byte changed without valid");
  rx_rise_a: assert property (rx_valid_out |->
    $past(spi_clk_in, 2)) else $error("rx valid not after rising edge");
  miso_fall_a: assert property ($changed(slave_data_output_out) &&
    slave_data_output_oe_out && $past(slave_data_output_oe_out) |->
    !$past(spi_clk_in, 3) || !$past(spi_clk_in, 5)) else $error("miso");
  take_sel_a: assert property (tx_take_out |->
    slave_data_output_oe_out) else $error("load while not driving");
  sio_slow_a: assert property (sio_grant_out && spi_enable_in |=>
    !sio_grant_out [*8]) else $error("grants too close");
  sio_fast_a: assert property (!spi_enable_in &&
    $past(!spi_enable_in) && sio_req_in |=> sio_grant_out)
    else $error("grant missing");
endmodule
bind spims_port spims_props i_props (.*);

/* File: tb/spims_host.sv */
// serial master model driving the mode 3 link
`timescale 1ns/10ps
module spims_host
(
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  localparam int HALF = 500;
  initial
  begin
    sclk_out = 1'h1;
    cs_n_out = 1'h1;
    mosi_out = 1'h0;
  end
  // n bits msb first; hold keeps the select low afterwards
  task automatic xfer(input logic [7:0] tx, input int n, input bit hold,
    output logic [7:0] rx);
    cs_n_out = 1'h0;
    #(HALF);
    for (int i = 7; i > 7 - n; i--)
    begin
      sclk_out = 1'h0;
      mosi_out = tx[i];
      #(HALF);
      sclk_out = 1'h1;
      rx = {rx[6:0], miso_in};
      #(HALF);
    end
    mosi_out = ~mosi_out;
    if (!hold) cs_n_out = 1'h1;
    #(HALF);
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the mode 3 serial slave port
`timescale 1ns/10ps
module testbench;
  logic sys_clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic en = 1'h0;
  logic ffi = 1'h0;
  logic req = 1'h0;
  logic [7:0] tx_byte = 8'h00;
  logic sclk, cs_n, mosi, miso_w, dout, oe, take, rxv, asel, ffo, grant, act;
  logic [7:0] rx_byte, got;
  logic [7:0] rxq[$];
  logic [7:0] tx_tab[4] = '{8'h96, 8'h5a, 8'hc3, 8'h0f};
  logic [7:0] rx_exp[3] = '{8'ha5, 8'h3c, 8'he1};
  int miscompares = 0;
  int samples_checked = 0;
  int takes = 0;
  int grants = 0;
  int g0;
  bit act_seen = 1'b0;
  always #4 sys_clk_in = ~sys_clk_in;
  assign miso_w = oe ? dout : 1'bz;
  spims_host i_host (.miso_in(miso_w), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));
  spims_port #(.SIO_SLOW_CYC(100)) i_dut (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .spi_clk_in(sclk), .cs_n_in(cs_n),
    .slave_data_input_in(mosi), .slave_data_output_out(dout),
    .slave_data_output_oe_out(oe), .spi_enable_in(en), .frame_full_in(ffi),
    .tx_byte_in(tx_byte), .tx_take_out(take), .rx_byte_out(rx_byte),
    .rx_valid_out(rxv), .active_out(act), .async_serial_sel_out(asel),
    .frame_full_out(ffo), .sio_req_in(req), .sio_grant_out(grant));
  always @(posedge sys_clk_in)
  begin
    if (take === 1'h1) takes <= takes + 1;
    if (grant === 1'h1) grants <= grants + 1;
    if (act === 1'h1) act_seen <= 1'b1;
    if (rxv === 1'h1) rxq.push_back(rx_byte);
    tx_byte <= tx_tab[(takes + int'(take === 1'h1)) % 4];
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    check({asel, ffo, oe, dout, rxv, take, grant, act}, 8'h90);
    rstn_in <= 1'h1;
    repeat (8) @(posedge sys_clk_in);
    i_host.xfer(8'h77, 8, 1'b0, got);
    check(8'(takes + rxq.size()), 8'h00);
    check(8'(act_seen), 8'h00);
    $display("test disabled done");
    @(posedge sys_clk_in);
    en <= 1'h1;
    ffi <= 1'h1;
    repeat (8) @(posedge sys_clk_in);
    check(8'({asel, ffo}), 8'h01);
    i_host.xfer(8'ha5, 8, 1'b1, got);
    check(got, tx_tab[0]);
    i_host.xfer(8'h3c, 8, 1'b0, got);
    check(got, tx_tab[1]);
    i_host.xfer(8'hff, 3, 1'b0, got);
    i_host.xfer(8'he1, 8, 1'b0, got);
    check(got, tx_tab[3]);
    repeat (10) @(posedge sys_clk_in);
    check(8'(rxq.size()), 8'h03);
    foreach (rx_exp[i]) check(rxq[i], rx_exp[i]);
    check(8'(act_seen), 8'h01);
    $display("test transfers done");
    req <= 1'h1;
    g0 = grants;
    repeat (300) @(posedge sys_clk_in);
    check(8'(grants - g0), 8'h03);
    en <= 1'h0;
    repeat (2) @(posedge sys_clk_in);
    g0 = grants;
    repeat (50) @(posedge sys_clk_in);
    check(8'(grants - g0 > 25), 8'h01);
    check(8'({asel, ffo}), 8'h02);
    $display("test pacing done");
    give_verdict;
  end
endmodule
